// file: verilog/flash_self_program_control.sv
// flash self-programming control: protected mode change and block erase
`timescale 1ns/1ps
module flash_self_program_control #(
  parameter int ERASE_CYCLES = flash_sp_pkg::ERASE_CYCLES,
  parameter int AW = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cpu_halt,
  output logic cpu_release,
  output logic self_mode,
  output logic erase_active,
  output logic [7:0] erase_block
);
  localparam int CW = $clog2(ERASE_CYCLES + 1);

  logic [7:0] cmd_r, aph_r, apl_r, aphc_r, aplc_r, prot_r, target_r;
  logic [2:0] status_r;
  logic fail_r;
  flash_sp_pkg::seq_state_t seq_r;
  logic [CW-1:0] cnt_r;
  logic [AW-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic aw_held_r, w_held_r;
  logic wr_go;
  logic [7:0] wbyte;

  // block n is protected when n < protected count held in protect reg
  function automatic logic blk_protected(input logic [7:0] blk,
                                         input logic [7:0] lim);
    blk_protected = (blk < lim);
  endfunction : blk_protected

  // write channel: address and data taken in either order
  assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wbyte = wdata_r[7:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_r && !s_axi_awready;
      s_axi_wready <= !w_held_r && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (wr_go) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (wr_go) begin
        w_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= flash_sp_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      if (awaddr_r > flash_sp_pkg::OFF_CTRL || awaddr_r[1:0] != 2'b00)
        s_axi_bresp <= flash_sp_pkg::RESP_SLVERR;
      else
        s_axi_bresp <= flash_sp_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // plain configuration registers, written only when lane 0 is enabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_r <= flash_sp_pkg::CMD_NONE;
      aph_r <= flash_sp_pkg::BYTE_ZERO;
      apl_r <= flash_sp_pkg::BYTE_ZERO;
      aphc_r <= flash_sp_pkg::BYTE_ZERO;
      aplc_r <= flash_sp_pkg::BYTE_ZERO;
      prot_r <= flash_sp_pkg::PROTECT_RESET;
    end else if (wr_go && wstrb_r[0]) begin
      if (awaddr_r == flash_sp_pkg::OFF_CMD) cmd_r <= wbyte;
      else if (awaddr_r == flash_sp_pkg::OFF_APH) aph_r <= wbyte;
      else if (awaddr_r == flash_sp_pkg::OFF_APL) apl_r <= wbyte;
      else if (awaddr_r == flash_sp_pkg::OFF_APHC) aphc_r <= wbyte;
      else if (awaddr_r == flash_sp_pkg::OFF_APLC) aplc_r <= wbyte;
      else if (awaddr_r == flash_sp_pkg::OFF_PROTECT) prot_r <= wbyte;
    end
  end

  // protected sequence; any other write in between breaks it
  logic wr_lane0, wr_pcmd, wr_mode, seq_fail;
  assign wr_lane0 = wr_go && wstrb_r[0];
  assign wr_pcmd = wr_lane0 && awaddr_r == flash_sp_pkg::OFF_PROTECT_CMD;
  assign wr_mode = wr_lane0 && awaddr_r == flash_sp_pkg::OFF_MODE;
  always_comb begin
    seq_fail = 1'b0;
    case (seq_r)
      flash_sp_pkg::SEQ_IDLE: seq_fail = wr_mode;
      flash_sp_pkg::SEQ_UNLOCKED: seq_fail = wr_go && !wr_mode;
      flash_sp_pkg::SEQ_GOT_VALUE:
        seq_fail = wr_go && !(wr_mode && wbyte == ~target_r);
      flash_sp_pkg::SEQ_GOT_INVERSE:
        seq_fail = wr_go && !(wr_mode && wbyte == target_r);
      default: seq_fail = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_r <= flash_sp_pkg::SEQ_IDLE;
      target_r <= flash_sp_pkg::MODE_NORMAL;
      self_mode <= 1'b0;
    end else if (seq_fail) begin
      seq_r <= flash_sp_pkg::SEQ_IDLE;
    end else if (wr_go) begin
      case (seq_r)
        flash_sp_pkg::SEQ_IDLE:
          if (wr_pcmd && wbyte == flash_sp_pkg::UNLOCK_CODE)
            seq_r <= flash_sp_pkg::SEQ_UNLOCKED;
        flash_sp_pkg::SEQ_UNLOCKED: begin
          target_r <= wbyte;
          seq_r <= flash_sp_pkg::SEQ_GOT_VALUE;
        end
        flash_sp_pkg::SEQ_GOT_VALUE: seq_r <= flash_sp_pkg::SEQ_GOT_INVERSE;
        flash_sp_pkg::SEQ_GOT_INVERSE: begin
          // 00h returns to normal, 01h enters self mode
          self_mode <= (target_r == flash_sp_pkg::MODE_SELF);
          seq_r <= flash_sp_pkg::SEQ_IDLE;
        end
        default: seq_r <= flash_sp_pkg::SEQ_IDLE;
      endcase
    end
  end

  // erase engine: halt in self mode starts the selected command
  logic start, done, prot_hit, bad_ptr;
  assign start = cpu_halt && self_mode && !erase_active && !cpu_release;
  assign done = erase_active && cnt_r == CW'(1);
  assign prot_hit = blk_protected(aph_r, prot_r);
  assign bad_ptr = (aph_r != aphc_r) || (apl_r != flash_sp_pkg::BYTE_ZERO)
                   || (aplc_r != flash_sp_pkg::BYTE_ZERO);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      erase_active <= 1'b0;
      erase_block <= flash_sp_pkg::BYTE_ZERO;
      cnt_r <= '0;
      cpu_release <= 1'b0;
    end else begin
      cpu_release <= 1'b0;
      if (start) begin
        if (cmd_r == flash_sp_pkg::CMD_BLOCK_ERASE && !prot_hit
            && !bad_ptr) begin
          erase_active <= 1'b1;
          erase_block <= aph_r;
          cnt_r <= CW'(ERASE_CYCLES);
        end else begin
          cpu_release <= 1'b1;
        end
      end else if (done) begin
        erase_active <= 1'b0;
        cpu_release <= 1'b1;
      end else if (erase_active) begin
        cnt_r <= cnt_r - CW'(1);
      end
    end
  end

  // status: hardware set wins over a software clear in the same cycle
  logic st_wr;
  assign st_wr = wr_lane0 && awaddr_r == flash_sp_pkg::OFF_STATUS;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= '0;
      fail_r <= 1'b0;
    end else begin
      if (st_wr) status_r <= wbyte[2:0];
      if (seq_fail) status_r[flash_sp_pkg::ST_SEQ_ERR] <= 1'b1;
      if (start && cmd_r == flash_sp_pkg::CMD_BLOCK_ERASE) begin
        if (prot_hit)
          status_r[flash_sp_pkg::ST_PROT_ERR] <= 1'b1;
        else if (bad_ptr || fail_r)
          status_r[flash_sp_pkg::ST_VERIFY_ERR] <= 1'b1;
      end
      if (wr_lane0 && awaddr_r == flash_sp_pkg::OFF_CTRL)
        fail_r <= wbyte[flash_sp_pkg::CTRL_FAIL];
    end
  end

  // read channel, one cycle after address acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= flash_sp_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= flash_sp_pkg::RESP_OKAY;
        s_axi_rdata <= '0;
        if (s_axi_araddr == flash_sp_pkg::OFF_CMD)
          s_axi_rdata[7:0] <= cmd_r;
        else if (s_axi_araddr == flash_sp_pkg::OFF_STATUS)
          s_axi_rdata[2:0] <= status_r;
        else if (s_axi_araddr == flash_sp_pkg::OFF_MODE)
          s_axi_rdata[0] <= self_mode;
        else if (s_axi_araddr == flash_sp_pkg::OFF_APH)
          s_axi_rdata[7:0] <= aph_r;
        else if (s_axi_araddr == flash_sp_pkg::OFF_APL)
          s_axi_rdata[7:0] <= apl_r;
        else if (s_axi_araddr == flash_sp_pkg::OFF_APHC)
          s_axi_rdata[7:0] <= aphc_r;
        else if (s_axi_araddr == flash_sp_pkg::OFF_APLC)
          s_axi_rdata[7:0] <= aplc_r;
        else if (s_axi_araddr == flash_sp_pkg::OFF_PROTECT)
          s_axi_rdata[7:0] <= prot_r;
        else if (s_axi_araddr == flash_sp_pkg::OFF_CTRL)
          s_axi_rdata[1:0] <= {fail_r, erase_active};
        else if (s_axi_araddr != flash_sp_pkg::OFF_PROTECT_CMD)
          s_axi_rresp <= flash_sp_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : flash_self_program_control

// file: pkg/flash_sp_pkg.sv
// shared constants for the flash self-programming controller
package flash_sp_pkg;
  // register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_PROTECT_CMD = 8'h08;
  localparam logic [7:0] OFF_MODE = 8'h0C;
  localparam logic [7:0] OFF_APH = 8'h10;
  localparam logic [7:0] OFF_APL = 8'h14;
  localparam logic [7:0] OFF_APHC = 8'h18;
  localparam logic [7:0] OFF_APLC = 8'h1C;
  localparam logic [7:0] OFF_PROTECT = 8'h20;
  localparam logic [7:0] OFF_CTRL = 8'h24;
  // codes and values
  localparam logic [7:0] UNLOCK_CODE = 8'hA5;
  localparam logic [7:0] CMD_NONE = 8'h00;
  localparam logic [7:0] CMD_BLOCK_ERASE = 8'h03;
  localparam logic [7:0] MODE_NORMAL = 8'h00;
  localparam logic [7:0] MODE_SELF = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hFF;
  localparam logic [7:0] PROTECT_RESET = 8'h00;
  // status and control bit positions
  localparam int ST_SEQ_ERR = 0;
  localparam int ST_VERIFY_ERR = 1;
  localparam int ST_PROT_ERR = 2;
  localparam int CTRL_HALT = 0;
  localparam int CTRL_FAIL = 1;
  // erase time and its cycle count at 20 MHz
  localparam int CLK_HZ = 20000000;
  localparam int ERASE_TIME_US = 100;
  localparam int ERASE_CYCLES = (ERASE_TIME_US * (CLK_HZ / 1000000));
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_UNLOCKED = 2'b01,
    SEQ_GOT_VALUE = 2'b10,
    SEQ_GOT_INVERSE = 2'b11
  } seq_state_t;
endpackage : flash_sp_pkg

// file: bench/flash_self_program_control_monitor.sv
// assertion checker for the flash self-programming controller
`timescale 1ns/1ps
module flash_self_program_control_monitor #(
  parameter int ERASE_CYCLES = 2000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic cpu_halt,
  input wire logic cpu_release,
  input wire logic self_mode,
  input wire logic erase_active,
  input wire logic [7:0] erase_block
);
  logic [4:0] wr_hist_r;
  logic [15:0] run_cnt_r;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // the mode may only move a few cycles after a register write lands
  always_ff @(posedge aclk) begin
    if (!aresetn) wr_hist_r <= 5'h00;
    else wr_hist_r <= {wr_hist_r[3:0], s_axi_wvalid & s_axi_wready};
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) run_cnt_r <= 16'h0000;
    else if (erase_active) run_cnt_r <= run_cnt_r + 16'h0001;
    else run_cnt_r <= 16'h0000;
  end
  mode_by_write_a: assert property (
    $changed(self_mode) |-> |wr_hist_r)
    else $error("mode moved without a register write");
  release_pulse_a: assert property (
    cpu_release |=> !cpu_release)
    else $error("release longer than one cycle");
  release_cause_a: assert property (
    $rose(cpu_release) |-> $past(cpu_halt))
    else $error("release without halt");
  erase_start_a: assert property (
    $rose(erase_active) |-> $past(cpu_halt) && $past(self_mode))
    else $error("erase began without halt in self mode");
  erase_end_a: assert property (
    $fell(erase_active) |-> cpu_release)
    else $error("erase ended without release");
  erase_len_a: assert property (
    run_cnt_r <= ERASE_CYCLES + 2)
    else $error("erase ran too long");
  block_hold_a: assert property (
    erase_active && $past(erase_active) |-> $stable(erase_block))
    else $error("erase block moved during erase");
  normal_quiet_a: assert property (
    !self_mode && !erase_active |=> !erase_active)
    else $error("erase began in normal mode");
  cover property ($rose(erase_active));
  cover property ($rose(self_mode));
  cover property ($fell(self_mode));
endmodule : flash_self_program_control_monitor
bind flash_self_program_control flash_self_program_control_monitor #(
  .ERASE_CYCLES(ERASE_CYCLES)
) mon_u (.aclk(aclk), .aresetn(aresetn), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .cpu_halt(cpu_halt),
  .cpu_release(cpu_release), .self_mode(self_mode),
  .erase_active(erase_active), .erase_block(erase_block));

// file: bench/flash_self_program_control_bench.sv
// self-checking bench for the flash self-programming controller
`timescale 1ns/1ps
module flash_self_program_control_bench;
  localparam int EC = 4;
  logic aclk = 0, aresetn = 0, cpu_halt = 0, seen, s_axi_awready;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, cpu_release, self_mode, erase_active;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, erase_block, blk;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, rrsp, brsp;
  int n_fail = 0, n_checks = 0, cyc;
  flash_self_program_control #(.ERASE_CYCLES(EC), .AW(8)) dut_u (.*);
  initial forever #25 aclk = ~aclk;
  task automatic end_of_test;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    brsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    rrsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(rdat, exp);
  endtask : rd_chk
  // unlock, value, inverse, value; only the last may move the mode
  task automatic mseq(input logic [7:0] v, inv, input logic old);
    wr(flash_sp_pkg::OFF_PROTECT_CMD, flash_sp_pkg::UNLOCK_CODE);
    wr(flash_sp_pkg::OFF_MODE, v);
    wr(flash_sp_pkg::OFF_MODE, inv);
    chk(32'(self_mode), 32'(old));
    wr(flash_sp_pkg::OFF_MODE, v);
  endtask : mseq
  // the cpu leaves halt on the release edge, as a real core would
  // the bench acts as software running from memory not erased
  task automatic halt_op;
    seen = 1'b0;
    @(posedge aclk);
    cpu_halt <= 1'b1;
    for (cyc = 0; cyc < 300; cyc++) begin
      @(posedge aclk);
      if (erase_active) seen = 1'b1;
      if (erase_active) blk = erase_block;
      if (cpu_release) break;
    end
    cpu_halt <= 1'b0;
    chk(32'(cyc < 300), 32'h1);
  endtask : halt_op
  task automatic t_mode;
    rd_chk(flash_sp_pkg::OFF_MODE, 32'h0);
    mseq(flash_sp_pkg::MODE_SELF, 8'hFE, 1'b0);
    rd_chk(flash_sp_pkg::OFF_MODE, 32'h1);
    rd_chk(flash_sp_pkg::OFF_STATUS, 32'h0);
    wr(flash_sp_pkg::OFF_MODE, flash_sp_pkg::MODE_NORMAL);
    rd_chk(flash_sp_pkg::OFF_STATUS, 32'h1);
    wr(flash_sp_pkg::OFF_STATUS, 8'h00);
    wr(flash_sp_pkg::OFF_PROTECT_CMD, flash_sp_pkg::UNLOCK_CODE);
    wr(flash_sp_pkg::OFF_APH, 8'h00);
    mseq(flash_sp_pkg::MODE_NORMAL, 8'hFE, 1'b1);
    rd_chk(flash_sp_pkg::OFF_STATUS, 32'h1);
    rd_chk(flash_sp_pkg::OFF_MODE, 32'h1);
    wr(flash_sp_pkg::OFF_STATUS, 8'h00);
    rd_chk(flash_sp_pkg::OFF_STATUS, 32'h0);
    $display("t_mode done");
  endtask : t_mode
  task automatic t_erase;
    wr(flash_sp_pkg::OFF_CMD, flash_sp_pkg::CMD_BLOCK_ERASE);
    wr(flash_sp_pkg::OFF_APH, 8'h05);
    wr(flash_sp_pkg::OFF_APL, 8'h00);
    wr(flash_sp_pkg::OFF_APHC, 8'h05);
    wr(flash_sp_pkg::OFF_APLC, 8'h00);
    wr(flash_sp_pkg::OFF_CTRL, 8'h02);
    wr(flash_sp_pkg::OFF_STATUS, 8'h00);
    // no watchdog inside this block; software restarts it here
    halt_op();
    // an injected failure still runs the timer; the flag is set at start
    chk(32'(seen), 32'h1);
    rd_chk(flash_sp_pkg::OFF_STATUS, 32'h2);
    // retry after the failure, as the erase loop does
    wr(flash_sp_pkg::OFF_CTRL, 8'h00);
    wr(flash_sp_pkg::OFF_STATUS, 8'h00);
    halt_op();
    chk(32'(seen), 32'h1);
    chk(32'(blk), 32'h5);
    chk(32'(cyc >= EC), 32'h1);
    rd_chk(flash_sp_pkg::OFF_STATUS, 32'h0);
    // low compare not zero: refused at once with the verify error
    wr(flash_sp_pkg::OFF_APLC, 8'h01);
    wr(flash_sp_pkg::OFF_STATUS, 8'h00);
    halt_op();
    chk(32'(seen), 32'h0);
    rd_chk(flash_sp_pkg::OFF_STATUS, 32'h2);
    wr(flash_sp_pkg::OFF_APLC, 8'h00);
    wr(flash_sp_pkg::OFF_PROTECT, 8'h08);
    wr(flash_sp_pkg::OFF_STATUS, 8'h00);
    halt_op();
    chk(32'(seen), 32'h0);
    rd_chk(flash_sp_pkg::OFF_STATUS, 32'h4);
    wr(flash_sp_pkg::OFF_CMD, flash_sp_pkg::CMD_NONE);
    wr(flash_sp_pkg::OFF_STATUS, 8'h00);
    halt_op();
    chk(32'(seen), 32'h0);
    $display("t_erase done");
  endtask : t_erase
  task automatic t_exit;
    mseq(flash_sp_pkg::MODE_NORMAL, 8'hFF, 1'b1);
    rd_chk(flash_sp_pkg::OFF_MODE, 32'h0);
    // software restores clock and interrupt mask only now
    wr(flash_sp_pkg::OFF_CMD, flash_sp_pkg::CMD_BLOCK_ERASE);
    wr(flash_sp_pkg::OFF_PROTECT, 8'h00);
    chk(32'(brsp), 32'(flash_sp_pkg::RESP_OKAY));
    cpu_halt <= 1'b1;
    seen = 1'b0;
    repeat (8) begin
      @(posedge aclk);
      if (erase_active || cpu_release) seen = 1'b1;
    end
    cpu_halt <= 1'b0;
    chk(32'(seen), 32'h0);
    rd_chk(8'h40, 32'h0);
    chk(32'(rrsp), 32'(flash_sp_pkg::RESP_SLVERR));
    wr(8'h40, 8'h00);
    chk(32'(brsp), 32'(flash_sp_pkg::RESP_SLVERR));
    $display("t_exit done");
  endtask : t_exit
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    $display("Error at %0t: watchdog expired", $time);
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_mode();
    t_erase();
    t_exit();
    end_of_test();
  end
endmodule : flash_self_program_control_bench
